// ===== src/ser_pkg.sv
// constants and check-code helpers for the error reporting unit
// assumes one system clock; no software-visible registers
package ser_pkg;
	localparam int SER_MST_W = 4;
	localparam int SER_NMST = 16;
	localparam int SER_AW = 32;
	localparam int SER_DW = 32;
	localparam int SER_CW = 7;
	localparam int SER_RF_AW = 5;
	localparam int SER_CACHE_CHK = 4;
	localparam int SER_LINE_W = 8;
	localparam int SER_CNT_W = 16;
	localparam logic [2:0] SER_FIX_CYCLES = 3'h6;
	localparam logic [7:0] SER_TRAP_IACC = 8'h01;
	localparam logic [7:0] SER_TRAP_DACC = 8'h09;
	localparam logic [7:0] SER_TRAP_REGACC = 8'h20;
	localparam logic [7:0] SER_TRAP_DSTORE = 8'h2b;
	localparam logic [1:0] SER_ACC_FETCH = 2'h0;
	localparam logic [1:0] SER_ACC_LOAD = 2'h1;
	localparam logic [1:0] SER_ACC_STORE = 2'h2;

	typedef enum logic [2:0] {
		SER_L2_IDLE = 3'h1,
		SER_L2_RD = 3'h2,
		SER_L2_WR = 3'h4
	} ser_l2_st_t;

	typedef enum logic [2:0] {
		SER_RF_IDLE = 3'h1,
		SER_RF_CHK = 3'h2,
		SER_RF_FIX = 3'h4
	} ser_rf_st_t;

	// single-error-correct, double-error-detect code over one data word
	function automatic logic [SER_CW-1:0] ser_ecc_gen(input logic [SER_DW-1:0] d);
		logic [38:0] cw;
		logic [SER_CW-1:0] c;
		int k;
		cw = '0;
		c = '0;
		k = 0;
		for (int p = 1; p < 39; p++) begin
			if ((p & (p - 1)) != 0) begin
				cw[p] = d[k];
				k++;
			end
		end
		for (int i = 0; i < 6; i++) begin
			for (int p = 1; p < 39; p++) begin
				if (p[i]) begin
					c[i] = c[i] ^ cw[p];
				end
			end
		end
		c[6] = ^{d, c[5:0]};
		return c;
	endfunction

	// one parity bit per byte of a cache word
	function automatic logic [SER_CACHE_CHK-1:0] ser_cache_par(input logic [SER_DW-1:0] d);
		logic [SER_CACHE_CHK-1:0] c;
		for (int b = 0; b < SER_CACHE_CHK; b++) begin
			c[b] = ^d[b*8 +: 8];
		end
		return c;
	endfunction
endpackage

// ===== src/ser_rf_if.sv
// carrier between the error unit and its register file memory
// assumes both ends share the system clock
`timescale 1ns/1ps
interface ser_rf_if;
	import ser_pkg::*;
	logic [SER_RF_AW-1:0] rd_addr_a;
	logic [SER_DW+SER_CW-1:0] rd_data_a;
	logic [SER_RF_AW-1:0] rd_addr_b;
	logic [SER_DW+SER_CW-1:0] rd_data_b;
	logic we;
	logic [SER_RF_AW-1:0] waddr;
	logic [SER_DW+SER_CW-1:0] wdata;
	modport mem (input rd_addr_a, rd_addr_b, we, waddr, wdata, output rd_data_a, rd_data_b);
	modport user (output rd_addr_a, rd_addr_b, we, waddr, wdata, input rd_data_a, rd_data_b);
endinterface

// ===== src/ser_secded.sv
// combinational check and repair of one stored register word
// assumes the check bits were made by ser_ecc_gen
`timescale 1ns/1ps
module ser_secded
	import ser_pkg::*;
(
	input wire logic [SER_DW-1:0] i_data,
	input wire logic [SER_CW-1:0] i_chk,
	output logic [SER_DW-1:0] o_data,
	output logic o_single,
	output logic o_double
);
	logic [5:0] syn;
	logic ovr;
	logic [SER_CW-1:0] regen;

	// syndrome names the flipped position; overall parity tells one from two
	always_comb begin
		int k;
		k = 0;
		regen = ser_ecc_gen(i_data);
		syn = regen[5:0] ^ i_chk[5:0];
		ovr = ^{i_data, i_chk};
		o_data = i_data;
		for (int p = 1; p < 39; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (p == int'(syn)) begin
					o_data[k] = ~i_data[k];
				end
				k++;
			end
		end
		o_single = ovr;
		o_double = (syn != 6'h00) && !ovr;
	end
endmodule

// ===== src/ser_regmem.sv
// register file storage: one write port, two registered read ports
// assumes the user side arbitrates the write port
`timescale 1ns/1ps
module ser_regmem
	import ser_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	ser_rf_if.mem rf
);
	logic [SER_DW+SER_CW-1:0] mem [0:(1<<SER_RF_AW)-1];

	// array has no reset; contents are undefined until written
	always_ff @(posedge i_sys_clk) begin
		if (rf.we) begin
			mem[rf.waddr] <= rf.wdata;
		end
	end

	// read data leave from registers
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rf.rd_data_a <= '0;
			rf.rd_data_b <= '0;
		end else begin
			rf.rd_data_a <= mem[rf.rd_addr_a];
			rf.rd_data_b <= mem[rf.rd_addr_b];
		end
	end
endmodule

// ===== src/ser_top.sv
// error detection and reporting: io access guard, l2 guard, traps, register
// file and cache checking; every input is from logic on the system clock
`timescale 1ns/1ps
// Overview of operation
// RL1: io guard answers violations with error
// RL2: l2 protected area access gets error
// RL3: uncorrectable memory error passed on as error
// RL4: io guard records offending master and address
// RL5: io guard may interrupt on violation
// RL6: violating io core halted, status bit set
// RL7: l2 interrupts on failed posted write
// RL8: load error trap 0x09, store 0x2b
// RL9: fetch error gives trap 0x01
// RL10: software masks store traps, uses monitor
// RL11: corrected-data side-band feeds the scrubber
// RL12: scrubber counts corrected memory errors
// RL13: register words carry correcting check code
// RL14: single error stalls instruction six cycles
// RL15: double register error gives trap 0x20
// RL16: cache words carry four check bits
// RL17: cache error flushes line, re-executes instruction
// RL18: mmu register error raises page fault
// RL19: memories reachable by diagnostic read/write
module ser_top
	import ser_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_io_req,
	input wire logic [SER_MST_W-1:0] i_io_mst,
	input wire logic [SER_AW-1:0] i_io_addr,
	input wire logic [SER_NMST-1:0] i_io_perm,
	input wire logic i_iommu_irq_en,
	input wire logic i_iommu_irq_clr,
	input wire logic [SER_NMST-1:0] i_io_halt_clr,
	output logic o_io_resp_ok,
	output logic o_io_resp_err,
	output logic o_io_viol_valid,
	output logic [SER_MST_W-1:0] o_io_viol_mst,
	output logic [SER_AW-1:0] o_io_viol_addr,
	output logic o_iommu_irq,
	output logic [SER_NMST-1:0] o_io_halt,
	input wire logic i_l2_req,
	input wire logic i_l2_write,
	input wire logic [SER_AW-1:0] i_l2_addr,
	input wire logic i_l2_prot_en,
	input wire logic [SER_AW-1:0] i_l2_prot_base,
	input wire logic [SER_AW-1:0] i_l2_prot_limit,
	input wire logic i_l2_irq_clr,
	output logic o_l2_ready,
	output logic o_l2_resp_ok,
	output logic o_l2_resp_err,
	output logic [SER_DW-1:0] o_l2_rdata,
	output logic o_l2_irq,
	output logic o_mc_req,
	output logic o_mc_write,
	output logic [SER_AW-1:0] o_mc_addr,
	input wire logic i_mc_ack,
	input wire logic i_mc_uncorr,
	input wire logic i_mc_corr,
	input wire logic [SER_DW-1:0] i_mc_rdata,
	input wire logic i_busmon_clr,
	output logic o_busmon_irq,
	output logic o_corr_sideband,
	input wire logic i_scrub_cnt_clr,
	output logic [SER_CNT_W-1:0] o_scrub_cnt,
	input wire logic i_cpu_err,
	input wire logic [1:0] i_cpu_acc,
	input wire logic i_mmu_reg_err,
	output logic o_trap_valid,
	output logic [7:0] o_trap_code,
	output logic o_page_fault,
	input wire logic i_rf_rd,
	input wire logic [SER_RF_AW-1:0] i_rf_raddr,
	input wire logic i_rf_we,
	input wire logic [SER_RF_AW-1:0] i_rf_waddr,
	input wire logic [SER_DW-1:0] i_rf_wdata,
	output logic o_rf_rvalid,
	output logic [SER_DW-1:0] o_rf_rdata,
	output logic o_rf_stall,
	input wire logic i_cache_acc,
	input wire logic [SER_DW-1:0] i_cache_word,
	input wire logic [SER_CACHE_CHK-1:0] i_cache_chk,
	input wire logic [SER_LINE_W-1:0] i_cache_line,
	input wire logic [SER_DW-1:0] i_cache_wdata,
	output logic [SER_CACHE_CHK-1:0] o_cache_wchk,
	output logic o_cache_flush,
	output logic [SER_LINE_W-1:0] o_cache_flush_line,
	output logic o_cache_reexec,
	input wire logic i_diag_req,
	input wire logic i_diag_we,
	input wire logic [SER_RF_AW-1:0] i_diag_addr,
	input wire logic [SER_DW+SER_CW-1:0] i_diag_wdata,
	output logic o_diag_ack,
	output logic [SER_DW+SER_CW-1:0] o_diag_rdata
);
	ser_rf_if rf ();
	ser_l2_st_t l2_st_r, l2_st_nxt;
	ser_rf_st_t rf_st_r;
	logic io_viol, l2_prot, l2_take, busmon_set;
	logic [SER_DW-1:0] fix_data;
	logic fix_single, fix_double;
	logic [SER_DW-1:0] fix_data_r;
	logic [SER_RF_AW-1:0] rf_addr_r;
	logic [2:0] fix_cnt_r;
	logic wb_we, pipe_we, diag_we, diag_d1_r;

	// io access guard: a master without permission is refused
	assign io_viol = i_io_req && !i_io_perm[i_io_mst];
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_io_resp_ok <= 1'b0;
			o_io_resp_err <= 1'b0;
			o_io_viol_valid <= 1'b0;
			o_io_viol_mst <= '0;
			o_io_viol_addr <= '0;
		end else begin
			o_io_resp_ok <= i_io_req && !io_viol;
			o_io_resp_err <= io_viol; // see RL1
			o_io_viol_valid <= io_viol;
			if (io_viol) begin
				o_io_viol_mst <= i_io_mst; // see RL4
				o_io_viol_addr <= i_io_addr; // see RL4
			end
		end
	end

	// sticky flags: a set in the clear cycle wins so no event is lost
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_iommu_irq <= 1'b0;
			o_io_halt <= '0;
		end else begin
			o_iommu_irq <= (io_viol && i_iommu_irq_en) || (o_iommu_irq && !i_iommu_irq_clr); // see RL5
			for (int m = 0; m < SER_NMST; m++) begin
				o_io_halt[m] <= (io_viol && (i_io_mst == m[SER_MST_W-1:0]))
					|| (o_io_halt[m] && !i_io_halt_clr[m]); // see RL6
			end
		end
	end

	// l2 front end: one access outstanding; writes are posted
	assign l2_prot = i_l2_prot_en && (i_l2_addr >= i_l2_prot_base)
		&& (i_l2_addr <= i_l2_prot_limit);
	assign l2_take = (l2_st_r == SER_L2_IDLE) && i_l2_req;
	always_comb begin
		case (l2_st_r)
			SER_L2_IDLE: l2_st_nxt = (i_l2_req && !l2_prot)
				? (i_l2_write ? SER_L2_WR : SER_L2_RD) : SER_L2_IDLE;
			SER_L2_RD, SER_L2_WR: l2_st_nxt = i_mc_ack ? SER_L2_IDLE : l2_st_r;
			default: l2_st_nxt = SER_L2_IDLE;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			l2_st_r <= SER_L2_IDLE;
			o_l2_ready <= 1'b0;
			o_l2_resp_ok <= 1'b0;
			o_l2_resp_err <= 1'b0;
			o_l2_rdata <= '0;
			o_mc_req <= 1'b0;
			o_mc_write <= 1'b0;
			o_mc_addr <= '0;
		end else begin
			l2_st_r <= l2_st_nxt;
			o_l2_ready <= (l2_st_nxt == SER_L2_IDLE);
			o_mc_req <= l2_take && !l2_prot;
			if (l2_take) begin
				o_mc_write <= i_l2_write;
				o_mc_addr <= i_l2_addr;
			end
			// protected area refused at once; posted write acked at once
			o_l2_resp_err <= (l2_take && l2_prot) // see RL2
				|| (l2_st_r == SER_L2_RD && i_mc_ack && i_mc_uncorr); // see RL3
			o_l2_resp_ok <= (l2_take && !l2_prot && i_l2_write)
				|| (l2_st_r == SER_L2_RD && i_mc_ack && !i_mc_uncorr);
			if (l2_st_r == SER_L2_RD && i_mc_ack) begin
				o_l2_rdata <= i_mc_rdata;
			end
		end
	end

	// late write failure can only be told by interrupt; bus monitor sees any io or l2 error response
	assign busmon_set = o_io_resp_err || o_l2_resp_err; // see RL10
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_l2_irq <= 1'b0;
			o_busmon_irq <= 1'b0;
		end else begin
			o_l2_irq <= (l2_st_r == SER_L2_WR && i_mc_ack && i_mc_uncorr)
				|| (o_l2_irq && !i_l2_irq_clr); // see RL7
			o_busmon_irq <= busmon_set || (o_busmon_irq && !i_busmon_clr);
		end
	end

	// corrected-data side-band and saturating scrubber statistics
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_corr_sideband <= 1'b0;
			o_scrub_cnt <= '0;
		end else begin
			o_corr_sideband <= i_mc_ack && i_mc_corr; // see RL11
			if (o_corr_sideband && !(&o_scrub_cnt)) begin
				o_scrub_cnt <= o_scrub_cnt + 1'b1; // see RL12
			end else if (i_scrub_cnt_clr) begin
				o_scrub_cnt <= '0;
			end
		end
	end

	// trap mapping; a register file double error outranks a bus error
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_trap_valid <= 1'b0;
			o_trap_code <= '0;
			o_page_fault <= 1'b0;
		end else begin
			o_page_fault <= i_mmu_reg_err; // see RL18
			o_trap_valid <= (rf_st_r == SER_RF_CHK && fix_double) || i_cpu_err;
			if (rf_st_r == SER_RF_CHK && fix_double) begin
				o_trap_code <= SER_TRAP_REGACC; // see RL15
			end else if (i_cpu_err) begin
				case (i_cpu_acc)
					SER_ACC_FETCH: o_trap_code <= SER_TRAP_IACC; // see RL9
					SER_ACC_LOAD: o_trap_code <= SER_TRAP_DACC; // see RL8
					default: o_trap_code <= SER_TRAP_DSTORE; // see RL8
				endcase
			end
		end
	end

	// register file memory and its check
	ser_regmem u_mem (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.rf(rf.mem)
	);
	ser_secded u_dec (
		.i_data(rf.rd_data_a[SER_DW+SER_CW-1:SER_CW]),
		.i_chk(rf.rd_data_a[SER_CW-1:0]),
		.o_data(fix_data),
		.o_single(fix_single),
		.o_double(fix_double)
	);

	// write port: repair beats pipeline beats diagnostics
	assign wb_we = (rf_st_r == SER_RF_FIX) && (fix_cnt_r == SER_FIX_CYCLES - 3'h1);
	assign pipe_we = i_rf_we && !o_rf_stall && !wb_we;
	assign diag_we = i_diag_req && i_diag_we && !wb_we && !pipe_we;
	assign rf.rd_addr_a = i_rf_raddr;
	assign rf.rd_addr_b = i_diag_addr;
	assign rf.we = wb_we || pipe_we || diag_we;
	assign rf.waddr = wb_we ? rf_addr_r : (pipe_we ? i_rf_waddr : i_diag_addr);
	always_comb begin
		if (wb_we) begin
			rf.wdata = {fix_data_r, ser_ecc_gen(fix_data_r)}; // see RL13
		end else if (pipe_we) begin
			rf.wdata = {i_rf_wdata, ser_ecc_gen(i_rf_wdata)}; // see RL13
		end else begin
			rf.wdata = i_diag_wdata; // raw, so check bits can be corrupted on purpose
		end
	end

	// read, check, then answer, trap a double error, or spend six cycles repairing
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rf_st_r <= SER_RF_IDLE;
			rf_addr_r <= '0;
			fix_data_r <= '0;
			fix_cnt_r <= '0;
			o_rf_rvalid <= 1'b0;
			o_rf_rdata <= '0;
			o_rf_stall <= 1'b0;
		end else begin
			o_rf_rvalid <= 1'b0;
			case (rf_st_r)
				SER_RF_IDLE: begin
					if (i_rf_rd) begin
						rf_addr_r <= i_rf_raddr;
						rf_st_r <= SER_RF_CHK;
					end
				end
				SER_RF_CHK: begin
					if (fix_double) begin
						rf_st_r <= SER_RF_IDLE;
					end else if (fix_single) begin
						fix_data_r <= fix_data;
						fix_cnt_r <= SER_FIX_CYCLES - 3'h1;
						o_rf_stall <= 1'b1; // see RL14
						rf_st_r <= SER_RF_FIX;
					end else begin
						o_rf_rdata <= fix_data;
						o_rf_rvalid <= 1'b1;
						rf_st_r <= SER_RF_IDLE;
					end
				end
				SER_RF_FIX: begin
					if (fix_cnt_r == 3'h0) begin
						o_rf_stall <= 1'b0;
						o_rf_rdata <= fix_data_r;
						o_rf_rvalid <= 1'b1;
						rf_st_r <= SER_RF_IDLE;
					end else begin
						fix_cnt_r <= fix_cnt_r - 3'h1; // see RL14
					end
				end
				default: rf_st_r <= SER_RF_IDLE;
			endcase
		end
	end

	// diagnostic port answers two cycles after it is served
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			diag_d1_r <= 1'b0;
			o_diag_ack <= 1'b0;
			o_diag_rdata <= '0;
		end else begin
			diag_d1_r <= i_diag_req && (!i_diag_we || diag_we); // see RL19
			o_diag_ack <= diag_d1_r;
			if (diag_d1_r) begin
				o_diag_rdata <= rf.rd_data_b;
			end
		end
	end

	// cache checking: byte parity made on write, checked on every access
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_cache_wchk <= '0;
			o_cache_flush <= 1'b0;
			o_cache_flush_line <= '0;
			o_cache_reexec <= 1'b0;
		end else begin
			o_cache_wchk <= ser_cache_par(i_cache_wdata); // see RL16
			o_cache_flush <= i_cache_acc && (ser_cache_par(i_cache_word) != i_cache_chk);
			o_cache_reexec <= i_cache_acc && (ser_cache_par(i_cache_word) != i_cache_chk);
			if (i_cache_acc) begin
				o_cache_flush_line <= i_cache_line; // see RL17
			end
		end
	end

	sequence s_fix_start;
		rf_st_r == SER_RF_CHK && fix_single;
	endsequence
	sequence s_fix_stall;
		o_rf_stall [*6] ##1 (o_rf_rvalid && !o_rf_stall);
	endsequence
	chk_iommu_err_resp: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // see RL1
		io_viol |=> o_io_resp_err && !o_io_resp_ok) else $error("violation not refused");
	chk_iommu_record: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // see RL4
		io_viol |=> o_io_viol_mst == $past(i_io_mst) && o_io_viol_addr == $past(i_io_addr))
		else $error("violation not recorded");
	chk_iommu_irq_set: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // see RL5
		io_viol && i_iommu_irq_en |=> o_iommu_irq) else $error("guard interrupt missing");
	chk_io_core_halt: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // see RL6
		io_viol |=> o_io_halt[$past(i_io_mst)]) else $error("violating core not halted");
	chk_l2_prot_err: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // see RL2
		l2_take && l2_prot |=> o_l2_resp_err && !o_mc_req) else $error("protected access passed");
	chk_l2_uncorr: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // see RL3
		l2_st_r == SER_L2_RD && i_mc_ack && i_mc_uncorr |=> o_l2_resp_err)
		else $error("memory error not passed on");
	chk_l2_post_irq: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // see RL7
		l2_st_r == SER_L2_WR && i_mc_ack && i_mc_uncorr |=> o_l2_irq)
		else $error("posted write error lost");
	chk_trap_load: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // see RL8
		i_cpu_err && i_cpu_acc == SER_ACC_LOAD && !(rf_st_r == SER_RF_CHK && fix_double)
		|=> o_trap_valid && o_trap_code == 8'h09) else $error("wrong load trap");
	chk_trap_fetch: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // see RL9
		i_cpu_err && i_cpu_acc == SER_ACC_FETCH && !(rf_st_r == SER_RF_CHK && fix_double)
		|=> o_trap_code == 8'h01) else $error("wrong fetch trap");
	chk_rf_fix_stall: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // see RL14
		s_fix_start |=> s_fix_stall) else $error("repair stall not six cycles");
	chk_rf_double: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // see RL15
		rf_st_r == SER_RF_CHK && fix_double |=> o_trap_code == 8'h20 && !o_rf_rvalid)
		else $error("register error trap missing");
	chk_scrub_count: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // see RL12
		o_corr_sideband && !(&o_scrub_cnt) |=> o_scrub_cnt == $past(o_scrub_cnt) + 16'h0001)
		else $error("corrected error not counted");
	chk_cache_flush: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // see RL17
		i_cache_acc && ser_cache_par(i_cache_word) != i_cache_chk
		|=> o_cache_flush && o_cache_reexec && o_cache_flush_line == $past(i_cache_line))
		else $error("cache error not flushed");
endmodule

// ===== testbench/ser_mc_model.sv
// memory controller stand-in behind the l2 guard
// assumes one request outstanding, address held until the answer
`timescale 1ns/1ps
module ser_mc_model (
	input wire logic i_sys_clk,
	input wire logic i_mc_req,
	input wire logic [31:0] i_mc_addr,
	input wire logic [3:0] i_delay,
	input wire logic i_bad,
	input wire logic i_fix,
	output logic o_ack,
	output logic o_uncorr,
	output logic o_corr,
	output logic [31:0] o_rdata
);
	// idle qualifiers start high so a guard that ignores ack is caught
	initial begin
		o_ack = 1'b0;
		o_uncorr = 1'b1;
		o_corr = 1'b1;
		o_rdata = 32'hffff_ffff;
	end
	// one answer per request after the commanded wait
	always begin
		@(posedge i_sys_clk);
		#1;
		if (i_mc_req === 1'b1) begin
			repeat (i_delay) begin
				@(posedge i_sys_clk);
				#1;
			end
			o_ack = 1'b1;
			o_uncorr = i_bad;
			o_corr = i_fix;
			o_rdata = i_mc_addr ^ 32'h0f0f_f0f0;
			@(posedge i_sys_clk);
			#1;
			// released data flips so stale values never pass
			o_ack = 1'b0;
			o_uncorr = ~o_uncorr;
			o_corr = ~o_corr;
			o_rdata = ~o_rdata;
		end
	end
endmodule

// ===== testbench/test_ser_top.sv
// self-checking bench for the error reporting unit
// assumes one 100 MHz clock and the memory stand-in on the l2 side
`timescale 1ns/1ps
module test_ser_top;
	import ser_pkg::*;
	logic i_sys_clk = 1'b0, i_nrst = 1'b0, i_io_req = 1'b0, i_iommu_irq_en = 1'b0;
	logic i_iommu_irq_clr = 1'b0, i_l2_req = 1'b0, i_l2_write = 1'b0, i_l2_prot_en = 1'b0;
	logic i_l2_irq_clr = 1'b0, i_busmon_clr = 1'b0, i_scrub_cnt_clr = 1'b0, i_cpu_err = 1'b0;
	logic i_mmu_reg_err = 1'b0, i_rf_rd = 1'b0, i_rf_we = 1'b0, i_cache_acc = 1'b0;
	logic i_diag_req = 1'b0, i_diag_we = 1'b0, mc_bad = 1'b0, mc_fix = 1'b0;
	logic [1:0] i_cpu_acc = '0;
	logic [3:0] i_io_mst = '0, i_cache_chk = '0, mc_delay = '0;
	logic [4:0] i_rf_raddr = '0, i_rf_waddr = '0, i_diag_addr = '0;
	logic [7:0] i_cache_line = '0;
	logic [15:0] i_io_perm = '0, i_io_halt_clr = '0, exp_halt = '0, exp_cnt = '0;
	logic [31:0] i_io_addr = '0, i_l2_addr = '0, i_l2_prot_base = '0, i_l2_prot_limit = '0;
	logic [31:0] i_rf_wdata = '0, i_cache_word = '0, i_cache_wdata = '0;
	logic [38:0] i_diag_wdata = '0;
	logic i_mc_ack, i_mc_uncorr, i_mc_corr, o_io_resp_ok, o_io_resp_err, o_io_viol_valid;
	logic o_iommu_irq, o_l2_ready, o_l2_resp_ok, o_l2_resp_err, o_l2_irq, o_mc_req;
	logic o_mc_write, o_busmon_irq, o_corr_sideband, o_trap_valid, o_page_fault;
	logic o_rf_rvalid, o_rf_stall, o_cache_flush, o_cache_reexec, o_diag_ack;
	logic [3:0] o_io_viol_mst, o_cache_wchk;
	logic [7:0] o_trap_code, o_cache_flush_line;
	logic [15:0] o_io_halt, o_scrub_cnt;
	logic [31:0] o_io_viol_addr, o_l2_rdata, o_mc_addr, i_mc_rdata, o_rf_rdata;
	logic [38:0] o_diag_rdata;
	logic exp_irq = 1'b0, exp_mon = 1'b0, exp_l2irq = 1'b0;
	logic [7:0] tc[4] = '{8'h01, 8'h09, 8'h2b, 8'h2b};
	logic [31:0] rf_m[int];
	int mismatches = 0, n_checks = 0, cyc = 0;

	ser_top ser_top_inst (.*);
	ser_mc_model ser_mc_model_inst (.i_sys_clk(i_sys_clk), .i_mc_req(o_mc_req),
		.i_mc_addr(o_mc_addr), .i_delay(mc_delay), .i_bad(mc_bad), .i_fix(mc_fix),
		.o_ack(i_mc_ack), .o_uncorr(i_mc_uncorr), .o_corr(i_mc_corr), .o_rdata(i_mc_rdata));

	always #5 i_sys_clk = ~i_sys_clk;
	// hang guard; the sequence needs under two thousand cycles
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		if (mismatches == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// inputs move 1 ns after the edge so the design samples settled values
	task automatic stp(int n = 1);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask
	task automatic chk(string nm, logic [38:0] e, logic [38:0] g);
		n_checks++;
		if (e !== g) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic logic [3:0] par4(logic [31:0] d);
		for (int b = 0; b < 4; b++)
			par4[b] = ^d[b*8 +: 8];
	endfunction
	task automatic io_acc(logic [3:0] m, logic en);
		logic [31:0] a;
		logic bad;
		a = $urandom;
		bad = !i_io_perm[m];
		i_iommu_irq_en = en;
		i_io_req = 1'b1;
		i_io_mst = m;
		i_io_addr = a;
		stp();
		i_io_req = 1'b0;
		chk("io_resp", {bad, bad, !bad}, {o_io_resp_err, o_io_viol_valid, o_io_resp_ok});
		if (bad) begin
			exp_halt[m] = 1'b1;
			exp_irq |= en;
			exp_mon = 1'b1;
			chk("viol", {1'b1, m, a}, {o_io_viol_valid, o_io_viol_mst, o_io_viol_addr});
		end
		chk("halt", exp_halt, o_io_halt);
		chk("io_irq", exp_irq, o_iommu_irq);
		stp();
		chk("mon", exp_mon, o_busmon_irq);
	endtask
	// f[0] asks the controller for an uncorrectable error, f[1] for a corrected one
	task automatic l2_acc(logic w, logic [31:0] a, logic [1:0] f);
		logic prot;
		int k;
		prot = i_l2_prot_en && a >= i_l2_prot_base && a <= i_l2_prot_limit;
		exp_mon = prot | (!w & f[0]);
		mc_bad = f[0];
		mc_fix = f[1];
		mc_delay = 4'($urandom_range(4));
		i_busmon_clr = 1'b1;
		i_l2_req = 1'b1;
		i_l2_write = w;
		i_l2_addr = a;
		stp();
		i_l2_req = 1'b0;
		i_busmon_clr = 1'b0;
		chk("l2_prot", {prot, !prot}, {o_l2_resp_err, o_mc_req});
		if (!prot) begin
			chk("mc_fwd", {w, w, a}, {o_l2_resp_ok, o_mc_write, o_mc_addr});
			k = 0;
			do begin
				@(posedge i_sys_clk);
				k++;
			end while (i_mc_ack !== 1'b1 && k < 30);
			#1;
			exp_l2irq |= w & f[0];
			chk("l2_irq", exp_l2irq, o_l2_irq);
			chk("sideband", f[1], o_corr_sideband);
			if (!w) begin
				chk("l2_rd", {f[0], !f[0]}, {o_l2_resp_err, o_l2_resp_ok});
				if (!f[0]) begin
					chk("l2_data", a ^ 32'h0f0f_f0f0, o_l2_rdata);
				end
			end
			stp();
			exp_cnt += f[1];
			chk("scrub", exp_cnt, o_scrub_cnt);
		end
		stp();
		chk("l2_mon", exp_mon, o_busmon_irq);
		k = 0;
		while (o_l2_ready !== 1'b1 && k < 30) begin
			stp();
			k++;
		end
		chk("l2_ready", 1'b1, o_l2_ready);
	endtask
	task automatic diag(logic we, logic [4:0] a, logic [38:0] wd, output logic [38:0] rd);
		i_diag_req = 1'b1;
		i_diag_we = we;
		i_diag_addr = a;
		i_diag_wdata = wd;
		stp();
		i_diag_req = 1'b0;
		stp();
		chk("diag_ack", 1'b1, o_diag_ack);
		rd = o_diag_rdata;
	endtask
	// mode 0 clean word, 1 one flipped bit, 2 two flipped bits
	task automatic rf_read(logic [4:0] a, int mode);
		i_rf_rd = 1'b1;
		i_rf_raddr = a;
		stp();
		i_rf_rd = 1'b0;
		stp();
		if (mode == 2) begin
			chk("rf_trap", {2'b01, 8'h20}, {o_rf_rvalid, o_trap_valid, o_trap_code});
		end else begin
			for (int c = 2; c < 8 && mode == 1; c++) begin
				chk("rf_stall", 2'b10, {o_rf_stall, o_rf_rvalid});
				stp();
			end
			chk("rf_data", {2'b01, rf_m[a]}, {o_rf_stall, o_rf_rvalid, o_rf_rdata});
		end
		stp();
	endtask

	// main sequence: io guard, l2 path, register file, traps, cache
	initial begin
		logic [38:0] raw, junk;
		void'($urandom(32'h82a15e0d));
		repeat (5) @(posedge i_sys_clk);
		#1;
		i_nrst = 1'b1;
		i_io_perm = 16'($urandom);
		for (int i = 0; i < 12; i++) begin
			io_acc(4'($urandom), i[0]);
		end
		i_io_halt_clr = exp_halt;
		i_iommu_irq_clr = 1'b1;
		stp();
		i_io_halt_clr = '0;
		i_iommu_irq_clr = 1'b0;
		chk("io_clr", 17'h0, {o_io_halt, o_iommu_irq});
		i_l2_prot_en = 1'b1;
		i_l2_prot_base = 32'h4000_0000;
		i_l2_prot_limit = 32'h4000_0fff;
		l2_acc(1'b1, 32'h4000_0fff, 2'b00);
		l2_acc(1'b0, 32'h4000_0000, 2'b00);
		l2_acc(1'b0, 32'h4000_1000, 2'b00);
		l2_acc(1'b0, 32'h3fff_fffc, 2'b01);
		l2_acc(1'b0, 32'h4000_1004, 2'b10);
		l2_acc(1'b1, 32'h4000_2000, 2'b01);
		l2_acc(1'b1, 32'h4000_2004, 2'b10);
		i_l2_prot_en = 1'b0;
		l2_acc(1'b0, 32'h4000_0010, 2'b00);
		i_l2_irq_clr = 1'b1;
		i_scrub_cnt_clr = 1'b1;
		stp();
		i_l2_irq_clr = 1'b0;
		i_scrub_cnt_clr = 1'b0;
		chk("l2_clr", 17'h0, {o_l2_irq, o_scrub_cnt});
		for (int i = 0; i < 3; i++) begin
			int a;
			a = $urandom_range(31);
			rf_m[a] = $urandom;
			i_rf_we = 1'b1;
			i_rf_waddr = 5'(a);
			i_rf_wdata = rf_m[a];
			stp();
			i_rf_we = 1'b0;
			diag(1'b0, 5'(a), '0, raw);
			chk("diag_rd", rf_m[a], raw[38:7]);
			rf_read(5'(a), 0);
			diag(1'b1, 5'(a), raw ^ (39'h1 << $urandom_range(38)), junk);
			rf_read(5'(a), 1);
			diag(1'b0, 5'(a), '0, junk);
			chk("repair", raw, junk);
			diag(1'b1, 5'(a), raw ^ (39'h3 << $urandom_range(37)), junk);
			rf_read(5'(a), 2);
		end
		for (int a = 0; a < 4; a++) begin
			i_cpu_err = 1'b1;
			i_cpu_acc = 2'(a);
			i_mmu_reg_err = a[0];
			stp();
			i_cpu_err = 1'b0;
			i_mmu_reg_err = 1'b0;
			chk("trap", {1'b1, tc[a]}, {o_trap_valid, o_trap_code});
			chk("pfault", a[0], o_page_fault);
		end
		for (int i = 0; i < 4; i++) begin
			i_cache_wdata = $urandom;
			i_cache_word = $urandom;
			i_cache_line = 8'($urandom);
			i_cache_chk = par4(i_cache_word) ^ 4'(i[0]) << i[1];
			i_cache_acc = 1'b1;
			stp();
			i_cache_acc = 1'b0;
			chk("wchk", par4(i_cache_wdata), o_cache_wchk);
			chk("flush", {i[0], i[0]}, {o_cache_flush, o_cache_reexec});
			if (i[0]) begin
				chk("fline", i_cache_line, o_cache_flush_line);
			end
		end
		wrap_up();
	end
endmodule
